// File: design/cef_flag_bank.sv
// sticky edge flags, cleared by a written zero, written one ignored
// assumes a one-cycle write strobe from the register slave
`timescale 1ns/1ps
module cef_flag_bank
  import cef_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } cef_bank_s;

  cef_bank_s st;
  cef_bank_s next_st;
  logic [W-1:0] clr;

  always_comb begin
    next_st = st;
    clr     = i_wr ? ~i_wdata : '0;          // R3 R10
    // set applied after clear so a coincident edge is never lost
    next_st.flags = (st.flags & ~clr) | i_set; // R4 R14
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;

  a_set_wins : assert property (@(posedge i_core_clk) disable iff (i_reset) // R14
    (|i_set) |=> ((st.flags & $past(i_set)) == $past(i_set)))
    else $error("edge lost at flag");
  a_zero_clears : assert property (@(posedge i_core_clk) disable iff (i_reset) // R3
    i_wr |=> ((st.flags & ~$past(i_set) & ~$past(i_wdata)) == '0))
    else $error("written zero did not clear flag");
  a_one_keeps : assert property (@(posedge i_core_clk) disable iff (i_reset) // R4
    i_wr |=> ((st.flags & $past(st.flags) & $past(i_wdata))
              == ($past(st.flags) & $past(i_wdata))))
    else $error("written one changed flag");
  a_no_soft_set : assert property (@(posedge i_core_clk) disable iff (i_reset) // R10
    1'b1 |=> ((st.flags & ~$past(st.flags) & ~$past(i_set)) == '0))
    else $error("flag set without edge");
endmodule : cef_flag_bank

// File: design/cef_sync_edge.sv
// two-stage synchroniser with any-edge detection on a vector
// assumes inputs are asynchronous levels from analog comparators
`timescale 1ns/1ps
module cef_sync_edge
  import cef_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_edge
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [2:0]   primed;
  } cef_sync_s;

  cef_sync_s st;
  cef_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.s1     = i_raw;       // R14
    next_st.s2     = st.s1;       // R14
    next_st.s3     = st.s2;
    // a level that stands at release must reach s3 before any compare
    next_st.primed = {st.primed[1:0], 1'b1};
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // no edge until the history holds a real sample, so reset is not an edge
  assign o_edge = st.primed[2] ? (st.s2 ^ st.s3) : '0;  // R1

  a_edge_timing : assert property (@(posedge i_core_clk) disable iff (i_reset) // R14
    st.primed[2] |-> (o_edge == ($past(i_raw, 2) ^ $past(i_raw, 3))))
    else $error("edge not seen three cycles after input change");
endmodule : cef_sync_edge

// File: design/cef_top.sv
// comparator edge interrupt flags with AXI4-Lite register access
// assumes one core clock, asynchronous active-high reset, 32-bit bus data
`timescale 1ns/1ps
module cef_top
  import cef_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic [G1_W-1:0]   i_vcmp_out,
  input  wire logic [2:0]        i_presence_cmp,
  input  wire logic [2:0]        i_monitor_valid,
  output logic                   o_irq
);
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [G1_W-1:0]   en1;
    logic [G2_W-1:0]   en2;
    logic              irq;
  } cef_top_s;

  cef_top_s st;
  cef_top_s next_st;

  logic [G1_W-1:0] edge1;
  logic [G2_W-1:0] edge2;
  logic [G1_W-1:0] flags1;
  logic [G2_W-1:0] flags2;
  logic            wr_fire;
  logic            wr_lane;
  logic            wr_flags1;
  logic            wr_flags2;

  // bit n-1 carries comparator n, so the vector maps straight across
  cef_sync_edge #(.W(G1_W)) u_sync1 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_raw      (i_vcmp_out),                       // R5
    .o_edge     (edge1)
  );

  // presence comparators 4..2 on bits 5..3, monitor VALID 3..1 on bits 2..0
  cef_sync_edge #(.W(G2_W)) u_sync2 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_raw      ({i_presence_cmp, i_monitor_valid}), // R7 R8
    .o_edge     (edge2)
  );

  cef_flag_bank #(.W(G1_W)) u_flags1 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (edge1),                            // R1
    .i_wr       (wr_flags1),                        // R3
    .i_wdata    (st.w_data),
    .o_flags    (flags1)
  );

  cef_flag_bank #(.W(G2_W)) u_flags2 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (edge2),                            // R7 R8
    .i_wr       (wr_flags2),                        // R10
    .i_wdata    (st.w_data[G2_W-1:0]),              // R11
    .o_flags    (flags2)
  );

  // write happens once both address and data are held and no response waits
  assign wr_fire   = st.aw_held && st.w_held && !st.bvalid;
  assign wr_lane   = wr_fire && st.w_lane0;
  assign wr_flags1 = wr_lane && (st.aw_addr == ADDR_FLAGS1);
  assign wr_flags2 = wr_lane && (st.aw_addr == ADDR_FLAGS2);

  always_comb begin
    next_st = st;
    if (i_s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st.wready) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = i_s_axi_wdata[7:0];
      next_st.w_lane0 = i_s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      case (st.aw_addr)
        ADDR_FLAGS1, ADDR_FLAGS2: begin
          next_st.bresp = RESP_OKAY;
        end
        ADDR_EN1: begin
          if (st.w_lane0) begin
            next_st.en1 = st.w_data;                // R6
          end
        end
        ADDR_EN2: begin
          if (st.w_lane0) begin
            next_st.en2 = st.w_data[G2_W-1:0];      // R13
          end
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end else if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (i_s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      case (i_s_axi_araddr)
        ADDR_FLAGS1: begin
          next_st.rdata[G1_W-1:0] = flags1;
        end
        ADDR_EN1: begin
          next_st.rdata[G1_W-1:0] = st.en1;
        end
        ADDR_FLAGS2: begin
          next_st.rdata[G2_W-1:0] = flags2;         // R11
        end
        ADDR_EN2: begin
          next_st.rdata[G2_W-1:0] = st.en2;
        end
        default: begin
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // ready flops follow the hold state so outputs stay registered
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
    // one cycle of latency buys a glitch-free registered interrupt
    next_st.irq = (|(flags1 & st.en1))              // R2
                | (|(flags2 & st.en2));             // R9 R15
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.en1     <= RST_EN1;
      st.en2     <= RST_EN2;
    end else begin
      st <= next_st;
    end
  end

  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready  = st.wready;
  assign o_s_axi_bresp   = st.bresp;
  assign o_s_axi_bvalid  = st.bvalid;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rdata   = st.rdata;
  assign o_s_axi_rresp   = st.rresp;
  assign o_s_axi_rvalid  = st.rvalid;
  assign o_irq           = st.irq;

  a_irq_group1 : assert property (@(posedge i_core_clk) disable iff (i_reset) // R2
    (|(flags1 & st.en1)) |=> o_irq)
    else $error("group one request without interrupt");
  a_irq_group2 : assert property (@(posedge i_core_clk) disable iff (i_reset) // R9
    (|(flags2 & st.en2)) |=> o_irq)
    else $error("group two request without interrupt");
  a_irq_quiet : assert property (@(posedge i_core_clk) disable iff (i_reset) // R15
    !((|(flags1 & st.en1)) || (|(flags2 & st.en2))) |=> !o_irq)
    else $error("interrupt without enabled request");
  a_vcmp_to_flag : assert property (@(posedge i_core_clk) disable iff (i_reset) // R1
    (i_vcmp_out[7] != $past(i_vcmp_out[7])) && $past(!i_reset, 4)
      |-> ##3 flags1[7])
    else $error("comparator 8 edge did not set bit 7");
  a_presence_map : assert property (@(posedge i_core_clk) disable iff (i_reset) // R7
    edge2[5] |=> flags2[5])
    else $error("presence comparator 4 not on bit 5");
  a_valid_map : assert property (@(posedge i_core_clk) disable iff (i_reset) // R8
    $past(edge2[0]) && !$past(edge2[5:1] != 5'h00) |-> flags2[0])
    else $error("monitor 1 VALID change not on bit 0");
  a_top_bits_zero : assert property (@(posedge i_core_clk) disable iff (i_reset) // R11
    (i_s_axi_arvalid && st.arready && (i_s_axi_araddr == ADDR_FLAGS2))
      |=> (o_s_axi_rdata[7:6] == 2'h0))
    else $error("unused group two bits read nonzero");
  a_en1_write : assert property (@(posedge i_core_clk) disable iff (i_reset) // R6
    (wr_lane && (st.aw_addr == ADDR_EN1)) |=> (st.en1 == $past(st.w_data)))
    else $error("enable one write lost");
  a_en2_write : assert property (@(posedge i_core_clk) disable iff (i_reset) // R13
    (wr_lane && (st.aw_addr == ADDR_EN2)) |=> (st.en2 == $past(st.w_data[G2_W-1:0])))
    else $error("enable two write lost");
  a_bresp_hold : assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_s_axi_bvalid && !i_s_axi_bready) |=> (o_s_axi_bvalid && $stable(o_s_axi_bresp)))
    else $error("write response dropped before taken");
endmodule : cef_top

// File: dv/cef_cmp_model.sv
// behavioural comparators, presence switches and monitor valid lines
// assumes the bench asks for level changes as a one-cycle toggle mask
`timescale 1ns/1ps
module cef_cmp_model (
  input  wire logic        i_core_clk,
  input  wire logic [13:0] i_toggle,
  output logic      [7:0]  o_vcmp,
  output logic      [2:0]  o_presence,
  output logic      [2:0]  o_valid
);
  logic [13:0] lvl = 14'h0000;
  // change lands mid-cycle, unrelated to the edge, as an analog output would
  always @(posedge i_core_clk) begin
    lvl <= #37 lvl ^ i_toggle;
  end
  assign {o_valid, o_presence, o_vcmp} = lvl;
endmodule : cef_cmp_model

// File: dv/tb.sv
// self-checking bench for the comparator edge interrupt flags block
// assumes the package register map and the partner comparator model
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
  import cef_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [3:0]  strb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d, e1, e2, w;
  logic [13:0] tog = 14'h0000;
  logic [13:0] t;
  logic [7:0]  vcmp, f1;
  logic [2:0]  pres, vld;
  logic [5:0]  f2;
  logic [11:0] am [4];
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  cef_top u_dut (
    .i_core_clk(clk), .i_reset(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_vcmp_out(vcmp),
    .i_presence_cmp(pres), .i_monitor_valid(vld), .o_irq(irq)
  );

  cef_cmp_model u_model (
    .i_core_clk(clk), .i_toggle(tog), .o_vcmp(vcmp), .o_presence(pres), .o_valid(vld)
  );

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // cut a hang short; the whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rs);
    bit done;
    @(posedge clk);
    done = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dat;
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the wait ends on the write response; only the watchdog ends a hung wait
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        done = 1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
    bit done;
    @(posedge clk);
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        done = 1;
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd

  // levels held well past the two-stage synchroniser
  task automatic pulse(input logic [13:0] m);
    @(posedge clk);
    tog <= m;
    @(posedge clk);
    tog <= 14'h0000;
    repeat (8) @(posedge clk);
  endtask : pulse

  function automatic logic [5:0] g2(input logic [13:0] m);
    return {m[10:8], m[13:11]};
  endfunction : g2

  function automatic logic exp_irq(input logic [7:0] a1, b1, input logic [5:0] a2, b2);
    return (|(a1 & b1)) | (|(a2 & b2));
  endfunction : exp_irq

  initial begin
    d = $urandom(94);
    am = '{ADDR_FLAGS1, ADDR_EN1, ADDR_FLAGS2, ADDR_EN2};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(am[i], d, r);
      `CHK(d, 32'h0)
      `CHK(r, RESP_OKAY)
    end
    rd(12'hFFC, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(12'hFFC, 32'hFF, r);
    `CHK(r, RESP_SLVERR)
    // byte lane 0 off: accepted but the register keeps its value
    strb = 4'hE;
    wr(ADDR_EN1, 32'hFF, r);
    `CHK(r, RESP_OKAY)
    rd(ADDR_EN1, d, r);
    `CHK(d, 32'h0)
    strb = 4'hF;
    $display("test reset done");
    // second pass toggles back, so both edge directions are seen
    for (int i = 0; i < 28; i++) begin
      t = 14'h0001 << (i % 14);
      pulse(t);
      rd(ADDR_FLAGS1, d, r);
      `CHK(d, {24'h0, t[7:0]})
      rd(ADDR_FLAGS2, d, r);
      `CHK(d, {26'h0, g2(t)})
      wr(ADDR_FLAGS1, ~{18'h0, t}, r);
      wr(ADDR_FLAGS2, ~{26'h0, g2(t)}, r);
      rd(ADDR_FLAGS1, d, r);
      `CHK(d, 32'h0)
      rd(ADDR_FLAGS2, d, r);
      `CHK(d, 32'h0)
    end
    $display("test sweep done");
    // first round fully masked, second fully enabled, rest random
    for (int k = 0; k < 8; k++) begin
      e1 = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFF_FFFF : $urandom;
      e2 = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFF_FFFF : $urandom;
      t = $urandom;
      w = $urandom;
      wr(ADDR_EN1, e1, r);
      wr(ADDR_EN2, e2, r);
      rd(ADDR_EN1, d, r);
      `CHK(d, {24'h0, e1[7:0]})
      rd(ADDR_EN2, d, r);
      `CHK(d, {26'h0, e2[5:0]})
      pulse(t);
      f1 = t[7:0];
      f2 = g2(t);
      rd(ADDR_FLAGS1, d, r);
      `CHK(d, {24'h0, f1})
      rd(ADDR_FLAGS2, d, r);
      `CHK(d, {26'h0, f2})
      `CHK(irq, exp_irq(f1, e1[7:0], f2, e2[5:0]))
      wr(ADDR_FLAGS1, w, r);
      wr(ADDR_FLAGS2, w, r);
      f1 = f1 & w[7:0];
      f2 = f2 & w[5:0];
      rd(ADDR_FLAGS1, d, r);
      `CHK(d, {24'h0, f1})
      rd(ADDR_FLAGS2, d, r);
      `CHK(d, {26'h0, f2})
      `CHK(irq, exp_irq(f1, e1[7:0], f2, e2[5:0]))
      wr(ADDR_FLAGS1, 32'h0, r);
      wr(ADDR_FLAGS2, 32'h0, r);
      rd(ADDR_FLAGS2, d, r);
      `CHK(irq, 1'b0)
    end
    $display("test random done");
    // reset in mid-run with comparator levels left high must not flag an edge
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADDR_FLAGS1, d, r);
    `CHK(d, 32'h0)
    rd(ADDR_FLAGS2, d, r);
    `CHK(d, 32'h0)
    `CHK(irq, 1'b0)
    $display("test reset release done");
    complete_run();
  end
endmodule : tb

// File: inc/cef_pkg.sv
// constants and register map of the comparator edge interrupt flags block
// assumes a 32-bit AXI4-Lite master and a single 10 MHz core clock
// Summary of operation
// R1 - each of the eight voltage comparator flags sets on a rising or falling edge of its output.
// R2 - group one raises the interrupt while a flag and its matching enable are both one.
// R3 - writing zero to a group one flag clears it.
// R4 - writing one to a group one flag leaves it unchanged; only hardware sets flags.
// R5 - group one flag bit 7 serves comparator 8 down to bit 0 for comparator 1.
// R6 - group one enable bits sit at the same positions as their flags.
// R7 - group two bits 5, 4 and 3 set on any edge of presence comparators 4, 3 and 2.
// R8 - group two bits 2, 1 and 0 set on any change of monitor VALID 3, 2 and 1.
// R9 - group two raises the interrupt while a flag and its enable are both one.
// R10 - group two flags clear on a written zero and ignore a written one.
// R11 - the two top bits of the group two flag register are unused and ignore writes.
// R12 - software should read a flag before writing zero to clear it.
// R13 - group two enable bits 5 to 3 gate presence flags, bits 2 to 0 gate VALID flags.
// R14 - inputs pass two flip-flops before edge detection and a set beats a same-cycle clear.
// R15 - all enabled pending requests of both groups OR into one level interrupt line.
package cef_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          G1_W          = 8;
  localparam int          G2_W          = 6;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_FLAGS1    = 10'h053;
  localparam logic [9:0]  IDX_EN1       = 10'h054;
  localparam logic [9:0]  IDX_FLAGS2    = 10'h055;
  localparam logic [9:0]  IDX_EN2       = 10'h056;
  localparam logic [11:0] ADDR_FLAGS1   = {IDX_FLAGS1, 2'h0};
  localparam logic [11:0] ADDR_EN1      = {IDX_EN1, 2'h0};
  localparam logic [11:0] ADDR_FLAGS2   = {IDX_FLAGS2, 2'h0};
  localparam logic [11:0] ADDR_EN2      = {IDX_EN2, 2'h0};
  localparam logic [7:0]  RST_FLAGS1    = 8'h00;
  localparam logic [7:0]  RST_EN1       = 8'h00;
  localparam logic [5:0]  RST_FLAGS2    = 6'h00;
  localparam logic [5:0]  RST_EN2       = 6'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : cef_pkg
